// [bpr_pkg.sv]
package bpr_pkg;

   // Register offsets of the map.
   localparam logic [4:0] OFF_IDENTITY_INFO            = 5'h00;
   localparam logic [4:0] OFF_RATE_CLOCK_SETUP         = 5'h01;
   localparam logic [4:0] OFF_TEST_SIGNAL_SETUP        = 5'h02;
   localparam logic [4:0] OFF_REFERENCE_BIAS_SETUP     = 5'h03;
   localparam logic [4:0] OFF_LEADOFF_DETECT_SETUP     = 5'h04;
   localparam logic [4:0] OFF_CHANNEL_1_SETUP          = 5'h05;
   localparam logic [4:0] OFF_CHANNEL_2_SETUP          = 5'h06;
   localparam logic [4:0] OFF_CHANNEL_3_SETUP          = 5'h07;
   localparam logic [4:0] OFF_CHANNEL_4_SETUP          = 5'h08;
   localparam logic [4:0] OFF_CHANNEL_5_SETUP          = 5'h09;
   localparam logic [4:0] OFF_CHANNEL_6_SETUP          = 5'h0a;
   localparam logic [4:0] OFF_CHANNEL_7_SETUP          = 5'h0b;
   localparam logic [4:0] OFF_CHANNEL_8_SETUP          = 5'h0c;
   localparam logic [4:0] OFF_BIAS_DERIVE_POS_SELECT   = 5'h0d;
   localparam logic [4:0] OFF_BIAS_DERIVE_NEG_SELECT   = 5'h0e;
   localparam logic [4:0] OFF_LEADOFF_POS_SELECT       = 5'h0f;
   localparam logic [4:0] OFF_LEADOFF_NEG_SELECT       = 5'h10;
   localparam logic [4:0] OFF_LEADOFF_POLARITY_SWAP    = 5'h11;
   localparam logic [4:0] OFF_LEADOFF_POS_STATE        = 5'h12;
   localparam logic [4:0] OFF_LEADOFF_NEG_STATE        = 5'h13;
   localparam logic [4:0] OFF_GENERAL_PIN_CONTROL      = 5'h14;
   localparam logic [4:0] OFF_REFERENCE_ROUTE_CONTROL  = 5'h15;
   localparam logic [4:0] OFF_SPARE_CONTROL_B          = 5'h16;
   localparam logic [4:0] OFF_CONVERSION_LEADOFF_SETUP = 5'h17;

   // Reset values, indexed by offset; index 0 is the identity word and is not stored.
   localparam logic [7:0] REG_RESET [0:23] = '{
      8'h00, 8'h96, 8'hc0, 8'h60, 8'h00, 8'h61, 8'h61, 8'h61,
      8'h61, 8'h61, 8'h61, 8'h61, 8'h61, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00};

   // Identity word field positions and fixed values.
   localparam int         ID_REV_MSB    = 7;
   localparam int         ID_REV_LSB    = 5;
   localparam int         ID_RSVD_BIT   = 4;
   localparam int         ID_FAM_MSB    = 3;
   localparam int         ID_FAM_LSB    = 2;
   localparam int         ID_CH_MSB     = 1;
   localparam int         ID_CH_LSB     = 0;
   localparam logic       ID_RSVD_VALUE = 1'b1;
   // Arbitrary value.
   localparam logic [2:0] SILICON_REVISION_DEF = 3'h0;
   // Arbitrary value.
   localparam logic [1:0] FAMILY_CODE_DEF      = 2'h1;

   // Channel count codes and the matching present-channel masks.
   localparam logic [1:0] CH_CODE_4 = 2'h0;
   localparam logic [1:0] CH_CODE_6 = 2'h1;
   localparam logic [1:0] CH_CODE_8 = 2'h2;
   localparam logic [7:0] CH_MASK_4 = 8'h0f;
   localparam logic [7:0] CH_MASK_6 = 8'h3f;
   localparam logic [7:0] CH_MASK_8 = 8'hff;

   // Other field positions.
   localparam int CHSET_PD_BIT  = 7;
   localparam int BIAS_STAT_BIT = 0;

   // Command encodings.
   localparam logic [2:0] OP_READ         = 3'h1;
   localparam logic [2:0] OP_WRITE        = 3'h2;
   localparam logic [7:0] CMD_CONT_OUT    = 8'h10;
   localparam logic [7:0] CMD_STOP_CONT   = 8'h11;
   localparam logic       CONT_MODE_RESET = 1'b1;

   // Pin order in the synchroniser and its idle value (chip select high).
   localparam int         PIN_SCLK  = 0;
   localparam int         PIN_CSN   = 1;
   localparam int         PIN_DIN   = 2;
   localparam logic [2:0] PINS_IDLE = 3'h2;

   typedef enum logic [2:0] {
      ST_OPCODE = 3'b000,
      ST_COUNT  = 3'b001,
      ST_READ   = 3'b010,
      ST_WRITE  = 3'b011,
      ST_DONE   = 3'b100
   } bpr_state_e;

endpackage

// [bpr_byte_if.sv]
`timescale 1ns/1ps
// Byte-level link between the serial shifter and the command core.
interface bpr_byte_if;
   logic       rx_valid;
   logic [7:0] rx_byte;
   logic       frame_active;
   logic       tx_load;
   logic [7:0] tx_byte;

   modport shifter (output rx_valid, output rx_byte, output frame_active,
                    input tx_load, input tx_byte);
   modport core    (input rx_valid, input rx_byte, input frame_active,
                    output tx_load, output tx_byte);
endinterface

// [bpr_spi_shift.sv]
`timescale 1ns/1ps
module bpr_spi_shift
   import bpr_pkg::*;
(
   input  wire logic   clk_in,
   input  wire logic   arst_n_in,
   input  wire logic   ce_in,
   input  wire logic   sclk_in,
   input  wire logic   cs_n_in,
   input  wire logic   din_in,
   output logic        dout_out,
   bpr_byte_if.shifter link
);
   logic [2:0] meta_r;
   logic [2:0] sync_r;
   logic       sclk_d_r;
   logic       sclk_d_nxt;
   logic [7:0] rx_sh_r;
   logic [7:0] rx_sh_nxt;
   logic [2:0] bit_cnt_r;
   logic [2:0] bit_cnt_nxt;
   logic       rx_valid_r;
   logic       rx_valid_nxt;
   logic [7:0] rx_byte_r;
   logic [7:0] rx_byte_nxt;
   logic [7:0] tx_sh_r;
   logic [7:0] tx_sh_nxt;
   logic       dout_r;
   logic       dout_nxt;
   logic       sclk_rise;
   logic       sclk_fall;

   // Two-stage synchroniser for the serial pins; only sync_r is read by logic.
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         meta_r <= PINS_IDLE;
         sync_r <= PINS_IDLE;
      end
      else if (ce_in)
      begin
         meta_r <= {din_in, cs_n_in, sclk_in};
         sync_r <= meta_r;
      end
   end

   // Edges of the serial clock as seen in this domain.
   assign sclk_rise = sync_r[PIN_SCLK] & ~sclk_d_r;
   assign sclk_fall = ~sync_r[PIN_SCLK] & sclk_d_r;

   // Input is sampled on falling edges, output launched on rising edges, MSB first.
   always_comb
   begin
      sclk_d_nxt   = sync_r[PIN_SCLK];
      rx_sh_nxt    = rx_sh_r;
      bit_cnt_nxt  = bit_cnt_r;
      rx_valid_nxt = 1'b0;
      rx_byte_nxt  = rx_byte_r;
      tx_sh_nxt    = tx_sh_r;
      dout_nxt     = dout_r;
      if (sync_r[PIN_CSN])
      begin
         bit_cnt_nxt = 3'h0;
         tx_sh_nxt   = 8'h00;
         dout_nxt    = 1'b0;
      end
      else
      begin
         if (link.tx_load)
            tx_sh_nxt = link.tx_byte;
         else if (sclk_rise)
         begin
            dout_nxt  = tx_sh_r[7];
            tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
         end
         if (sclk_fall)
         begin
            rx_sh_nxt   = {rx_sh_r[6:0], sync_r[PIN_DIN]};
            bit_cnt_nxt = 3'(bit_cnt_r + 3'h1);
            if (bit_cnt_r == 3'h7)
            begin
               rx_valid_nxt = 1'b1;
               rx_byte_nxt  = {rx_sh_r[6:0], sync_r[PIN_DIN]};
            end
         end
      end
   end

   // Shifter state registers, frozen while the clock enable is low.
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         sclk_d_r   <= 1'b0;
         rx_sh_r    <= 8'h00;
         bit_cnt_r  <= 3'h0;
         rx_valid_r <= 1'b0;
         rx_byte_r  <= 8'h00;
         tx_sh_r    <= 8'h00;
         dout_r     <= 1'b0;
      end
      else if (ce_in)
      begin
         sclk_d_r   <= sclk_d_nxt;
         rx_sh_r    <= rx_sh_nxt;
         bit_cnt_r  <= bit_cnt_nxt;
         rx_valid_r <= rx_valid_nxt;
         rx_byte_r  <= rx_byte_nxt;
         tx_sh_r    <= tx_sh_nxt;
         dout_r     <= dout_nxt;
      end
   end

   // Byte results towards the core.
   assign link.rx_valid     = rx_valid_r;
   assign link.rx_byte      = rx_byte_r;
   assign link.frame_active = ~sync_r[PIN_CSN];
   assign dout_out          = dout_r;
endmodule

// [bpr_regbank.sv]
`timescale 1ns/1ps
// Functional notes
// - The identity word is fixed at build time and host writes never change it.
// - Identity bits 7 to 5 report the silicon revision as a read-only field.
// - Identity bit 4 always reads as one.
// - Identity bits 3 to 2 hold a fixed, read-only family code.
// - Identity bits 1 to 0 give the channel count: 00 four, 01 six, 10 eight.
// - Registers and per-channel bits of absent channels hold and read zero.
// - A read is opcode 001 plus start address, then 000 plus count minus one, then data out.
// - A write is opcode 010 plus start address, then 000 plus count minus one, then data MSB first.
module bpr_regbank
   import bpr_pkg::*;
#(
   parameter logic [2:0] SILICON_REVISION   = SILICON_REVISION_DEF,
   parameter logic [1:0] FAMILY_CODE        = FAMILY_CODE_DEF,
   parameter logic [1:0] CHANNEL_COUNT_CODE = CH_CODE_8
)
(
   input  wire logic       clk_in,
   input  wire logic       arst_n_in,
   input  wire logic       ce_in,
   input  wire logic       sclk_in,
   input  wire logic       cs_n_in,
   input  wire logic       din_in,
   input  wire logic [7:0] leadoff_pos_state_in,
   input  wire logic [7:0] leadoff_neg_state_in,
   input  wire logic       bias_stat_in,
   output logic            dout_out,
   output logic            cont_mode_out,
   output logic [7:0]      chan_pd_out,
   output logic [7:0]      rate_clock_setup_out
);
   localparam int NREG = 24;

   // Present-channel mask for a channel count code.
   function automatic logic [7:0] chan_mask(input logic [1:0] code);
      if (code == CH_CODE_4)
         chan_mask = CH_MASK_4;
      else if (code == CH_CODE_6)
         chan_mask = CH_MASK_6;
      else
         chan_mask = CH_MASK_8;
   endfunction

   localparam logic [7:0] PRESENT_MASK = chan_mask(CHANNEL_COUNT_CODE);

   bpr_byte_if link ();

   bpr_spi_shift u_shift (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .ce_in     (ce_in),
      .sclk_in   (sclk_in),
      .cs_n_in   (cs_n_in),
      .din_in    (din_in),
      .dout_out  (dout_out),
      .link      (link.shifter)
   );

   bpr_state_e state_r;
   bpr_state_e state_nxt;
   logic [4:0] addr_r;
   logic [4:0] addr_nxt;
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic       is_read_r;
   logic       is_read_nxt;
   logic       cont_r;
   logic       cont_nxt;
   logic       tx_load_r;
   logic       tx_load_nxt;
   logic [7:0] tx_byte_r;
   logic [7:0] tx_byte_nxt;
   logic       wr_en;
   logic [7:0] id_word;
   logic [7:0] regs_r   [1:NREG-1];
   logic [7:0] regs_nxt [1:NREG-1];

   // The identity word is built from constants and is never stored.
   assign id_word = {SILICON_REVISION, ID_RSVD_VALUE, FAMILY_CODE, CHANNEL_COUNT_CODE};

   // Read decode; addresses past the map read as zero.
   function automatic logic [7:0] rd_reg(input logic [4:0] a);
      if (a == OFF_IDENTITY_INFO)
         rd_reg = id_word;
      else if (a <= OFF_CONVERSION_LEADOFF_SETUP)
         rd_reg = regs_r[a];
      else
         rd_reg = 8'h00;
   endfunction

   // Value stored by a host write, given the old content.
   function automatic logic [7:0] wr_value(input logic [4:0] a, input logic [7:0] d,
                                           input logic [7:0] old);
      if (a == OFF_LEADOFF_POS_STATE || a == OFF_LEADOFF_NEG_STATE)
         wr_value = old;
      else if (a >= OFF_CHANNEL_1_SETUP && a <= OFF_CHANNEL_8_SETUP)
         wr_value = PRESENT_MASK[3'(a - OFF_CHANNEL_1_SETUP)] ? d : 8'h00;
      else if (a >= OFF_BIAS_DERIVE_POS_SELECT && a <= OFF_LEADOFF_POLARITY_SWAP)
         wr_value = d & PRESENT_MASK;
      else if (a == OFF_REFERENCE_BIAS_SETUP)
         wr_value = {d[7:1], old[BIAS_STAT_BIT]};
      else
         wr_value = d;
   endfunction

   // Command sequencer: opcode byte, count byte, then data bytes until the count runs out.
   always_comb
   begin
      state_nxt   = state_r;
      addr_nxt    = addr_r;
      cnt_nxt     = cnt_r;
      is_read_nxt = is_read_r;
      cont_nxt    = cont_r;
      tx_load_nxt = 1'b0;
      tx_byte_nxt = tx_byte_r;
      wr_en       = 1'b0;
      if (!link.frame_active)
         state_nxt = ST_OPCODE;
      else if (link.rx_valid)
      begin
         case (state_r)
            ST_OPCODE:
            begin
               if (link.rx_byte == CMD_STOP_CONT)
                  cont_nxt = 1'b0;
               else if (link.rx_byte == CMD_CONT_OUT)
                  cont_nxt = 1'b1;
               else if (!cont_r && (link.rx_byte[7:5] == OP_READ ||
                                    link.rx_byte[7:5] == OP_WRITE))
               begin
                  addr_nxt    = link.rx_byte[4:0];
                  is_read_nxt = (link.rx_byte[7:5] == OP_READ);
                  state_nxt   = ST_COUNT;
               end
            end
            ST_COUNT:
            begin
               cnt_nxt = link.rx_byte[4:0];
               if (is_read_r)
               begin
                  tx_load_nxt = 1'b1;
                  tx_byte_nxt = rd_reg(addr_r);
                  state_nxt   = ST_READ;
               end
               else
                  state_nxt = ST_WRITE;
            end
            ST_READ, ST_WRITE:
            begin
               wr_en = (state_r == ST_WRITE);
               if (cnt_r == 5'h00)
                  state_nxt = ST_DONE;
               else
               begin
                  addr_nxt = 5'(addr_r + 5'h01);
                  cnt_nxt  = 5'(cnt_r - 5'h01);
                  if (state_r == ST_READ)
                  begin
                     tx_load_nxt = 1'b1;
                     tx_byte_nxt = rd_reg(5'(addr_r + 5'h01));
                  end
               end
            end
            default:
               state_nxt = state_r;
         endcase
      end
   end

   // Sequencer registers.
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state_r   <= ST_OPCODE;
         addr_r    <= 5'h00;
         cnt_r     <= 5'h00;
         is_read_r <= 1'b0;
         cont_r    <= CONT_MODE_RESET;
         tx_load_r <= 1'b0;
         tx_byte_r <= 8'h00;
      end
      else if (ce_in)
      begin
         state_r   <= state_nxt;
         addr_r    <= addr_nxt;
         cnt_r     <= cnt_nxt;
         is_read_r <= is_read_nxt;
         cont_r    <= cont_nxt;
         tx_load_r <= tx_load_nxt;
         tx_byte_r <= tx_byte_nxt;
      end
   end

   assign link.tx_load = tx_load_r;
   assign link.tx_byte = tx_byte_r;

   // Register file next values: host writes, then status loads from hardware win.
   always_comb
   begin
      for (int i = 1; i < NREG; i++)
         regs_nxt[i] = regs_r[i];
      if (wr_en && addr_r != OFF_IDENTITY_INFO && addr_r <= OFF_CONVERSION_LEADOFF_SETUP)
         regs_nxt[addr_r] = wr_value(addr_r, link.rx_byte, regs_r[addr_r]);
      regs_nxt[OFF_LEADOFF_POS_STATE] = leadoff_pos_state_in & PRESENT_MASK;
      regs_nxt[OFF_LEADOFF_NEG_STATE] = leadoff_neg_state_in & PRESENT_MASK;
      regs_nxt[OFF_REFERENCE_BIAS_SETUP][BIAS_STAT_BIT] = bias_stat_in;
   end

   // Register file; absent channel setups come out of reset as zero.
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         for (int i = 1; i < NREG; i++)
            regs_r[i] <= (i >= 9 && i <= 12 && !PRESENT_MASK[i - 5]) ? 8'h00 : REG_RESET[i];
      end
      else if (ce_in)
      begin
         for (int i = 1; i < NREG; i++)
            regs_r[i] <= regs_nxt[i];
      end
   end

   // Settings towards the converter.
   assign cont_mode_out        = cont_r;
   assign rate_clock_setup_out = regs_r[OFF_RATE_CLOCK_SETUP];
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_pd
         assign chan_pd_out[g] = regs_r[5 + g][CHSET_PD_BIT];
      end
   endgenerate

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);

   sequence s_cmd_read;
      ce_in && link.rx_valid && state_r == ST_OPCODE && !cont_r && link.rx_byte[7:5] == OP_READ;
   endsequence
   sequence s_count_read;
      ce_in && link.rx_valid && state_r == ST_COUNT && is_read_r;
   endsequence
   sequence s_id_load;
      ce_in && link.rx_valid && state_r == ST_COUNT && is_read_r && addr_r == OFF_IDENTITY_INFO;
   endsequence

   a_read_cmd_decode: assert property (s_cmd_read |=> state_r == ST_COUNT && is_read_r
      && addr_r == $past(link.rx_byte[4:0]))
      else $error("read opcode not decoded");
   a_read_first_load: assert property (s_count_read |=> tx_load_r && state_r == ST_READ
      ##1 !tx_load_r)
      else $error("first read byte not loaded once");
   a_id_read_back: assert property (s_id_load
      |=> tx_byte_r == {SILICON_REVISION, ID_RSVD_VALUE, FAMILY_CODE, CHANNEL_COUNT_CODE})
      else $error("identity read returned wrong word");
   a_id_rev_field: assert property (s_id_load |=> tx_byte_r[ID_REV_MSB:ID_REV_LSB]
      == SILICON_REVISION)
      else $error("revision field wrong");
   a_id_rsvd_one: assert property (s_id_load |=> tx_byte_r[ID_RSVD_BIT] == 1'b1)
      else $error("identity reserved bit not one");
   a_id_family_code: assert property (s_id_load |=> tx_byte_r[ID_FAM_MSB:ID_FAM_LSB]
      == FAMILY_CODE)
      else $error("family code wrong");
   a_chan_count_code: assert property (s_id_load |=> tx_byte_r[ID_CH_MSB:ID_CH_LSB]
      == CHANNEL_COUNT_CODE && $countones(PRESENT_MASK) ==
      (CHANNEL_COUNT_CODE == CH_CODE_4 ? 4 : (CHANNEL_COUNT_CODE == CH_CODE_6 ? 6 : 8)))
      else $error("channel count code does not match mask");
   a_absent_reads_zero: assert property (((regs_r[OFF_BIAS_DERIVE_POS_SELECT]
      | regs_r[OFF_LEADOFF_POS_STATE] | regs_r[OFF_LEADOFF_NEG_STATE]) & ~PRESENT_MASK) == 8'h00
      && (PRESENT_MASK[7] || regs_r[OFF_CHANNEL_8_SETUP] == 8'h00))
      else $error("absent channel bit not zero");
   a_status_write_ignored: assert property (ce_in && wr_en && addr_r == OFF_LEADOFF_POS_STATE
      |=> regs_r[OFF_LEADOFF_POS_STATE] == ($past(leadoff_pos_state_in) & PRESENT_MASK))
      else $error("write changed lead-off state");
   a_write_stores_data: assert property (ce_in && wr_en && addr_r == OFF_RATE_CLOCK_SETUP
      |=> regs_r[OFF_RATE_CLOCK_SETUP] == $past(link.rx_byte))
      else $error("write data not stored");
   a_cont_blocks_read: assert property (ce_in && link.rx_valid && state_r == ST_OPCODE
      && cont_r && link.rx_byte[7:5] == OP_READ |=> state_r == ST_OPCODE)
      else $error("read accepted in continuous mode");

   // Trimmed writes, the live bias status bit, the end of a read and a closed frame.
   a_absent_chan_write: assert property (ce_in && wr_en && addr_r == OFF_CHANNEL_8_SETUP
      && !PRESENT_MASK[7] |=> regs_r[OFF_CHANNEL_8_SETUP] == 8'h00)
      else $error("absent channel setup took a write");
   a_bias_bit_kept: assert property (ce_in && wr_en && addr_r == OFF_REFERENCE_BIAS_SETUP
      |=> regs_r[OFF_REFERENCE_BIAS_SETUP][7:1] == $past(link.rx_byte[7:1])
      && regs_r[OFF_REFERENCE_BIAS_SETUP][BIAS_STAT_BIT] == $past(bias_stat_in))
      else $error("bias setup write not stored as expected");
   a_read_count_end: assert property (ce_in && link.rx_valid && link.frame_active
      && state_r == ST_READ && cnt_r == 5'h00 |=> state_r == ST_DONE && !tx_load_r)
      else $error("read did not stop at its count");
   a_frame_end_reset: assert property (ce_in && !link.frame_active
      |=> state_r == ST_OPCODE)
      else $error("sequencer not reset by deselect");
endmodule

// [bpr_host_model.sv]
`timescale 1ns/1ps
// Host side of the serial port: frames commands and shifts bytes in mode 1.
module bpr_host_model
(
   input  wire logic clk_in,
   input  wire logic dout_in,
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      din_out
);
   localparam int HALF_CLKS = 10; // Half of a 160 ns serial period.
   localparam int GAP_CLKS  = 6;  // Idle time after each byte.

   // Lines start idle: clock low, chip select high.
   initial
   begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      din_out  = 1'b0;
   end

   // Shifts one byte out MSB first and takes each reply bit before the falling edge.
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         @(posedge clk_in);
         sclk_out <= 1'b1;
         din_out  <= tx[i];
         repeat (HALF_CLKS) @(posedge clk_in);
         rx[i] = dout_in;
         sclk_out <= 1'b0;
         repeat (HALF_CLKS - 1) @(posedge clk_in);
      end
      // The released data line flips so a stale bit never passes for data.
      @(posedge clk_in);
      din_out <= ~din_out;
      repeat (GAP_CLKS) @(posedge clk_in);
   endtask

   // Selects the device and lets the selection settle.
   task automatic open_frame();
      @(posedge clk_in);
      cs_n_out <= 1'b0;
      repeat (4) @(posedge clk_in);
   endtask

   // Deselects the device, which ends any command in flight.
   task automatic close_frame();
      repeat (4) @(posedge clk_in);
      cs_n_out <= 1'b1;
      repeat (8) @(posedge clk_in);
   endtask
endmodule

// [test_biopotential_adc_register_map.sv]
`timescale 1ns/1ps
`define CHK(what, exp, got) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) \
      begin \
         $display("Error %s expected %h seen %h", what, exp, got); \
         num_errors++; \
      end \
   end
module test_biopotential_adc_register_map
   import bpr_pkg::*;
;
   localparam logic [1:0] VARIANT = CH_CODE_6;
   localparam logic [7:0] PRESENT = CH_MASK_6;

   logic       clk_in    = 1'b0;
   logic       arst_n_in = 1'b0;
   logic       sclk, cs_n, din, dout, cont_mode, bias_stat, ce;
   logic [7:0] lo_pos, lo_neg, chan_pd, rate_out, pd_exp;
   logic [7:0] mem  [0:31];
   logic [7:0] wbuf [0:31];
   logic [7:0] rbuf [0:31];
   integer     seed;
   int         num_errors = 0;
   int         n_checks   = 0;
   int         cycles     = 0;

   // Clock of 8 ns period.
   always #4 clk_in = ~clk_in;

   bpr_regbank #(.CHANNEL_COUNT_CODE(VARIANT)) dut_u (
      .clk_in               (clk_in),
      .arst_n_in            (arst_n_in),
      .ce_in                (ce),
      .sclk_in              (sclk),
      .cs_n_in              (cs_n),
      .din_in               (din),
      .leadoff_pos_state_in (lo_pos),
      .leadoff_neg_state_in (lo_neg),
      .bias_stat_in         (bias_stat),
      .dout_out             (dout),
      .cont_mode_out        (cont_mode),
      .chan_pd_out          (chan_pd),
      .rate_clock_setup_out (rate_out)
   );

   bpr_host_model host_u (
      .clk_in   (clk_in),
      .dout_in  (dout),
      .sclk_out (sclk),
      .cs_n_out (cs_n),
      .din_out  (din)
   );

   // Value a register should read, from the shadow copy and the live status inputs.
   function automatic logic [7:0] exp_rd(input logic [4:0] a);
      if (a == OFF_IDENTITY_INFO)
         return {SILICON_REVISION_DEF, ID_RSVD_VALUE, FAMILY_CODE_DEF, VARIANT};
      if (a == OFF_REFERENCE_BIAS_SETUP)
         return {mem[a][7:1], bias_stat};
      if (a == OFF_LEADOFF_POS_STATE)
         return lo_pos & PRESENT;
      if (a == OFF_LEADOFF_NEG_STATE)
         return lo_neg & PRESENT;
      return mem[a];
   endfunction

   // Updates the shadow copy the way a host write should land.
   task automatic shadow_wr(input logic [4:0] a, input logic [7:0] d);
      if (a == OFF_IDENTITY_INFO || a == OFF_LEADOFF_POS_STATE ||
          a == OFF_LEADOFF_NEG_STATE || a > OFF_CONVERSION_LEADOFF_SETUP)
         return;
      if (a >= OFF_CHANNEL_1_SETUP && a <= OFF_CHANNEL_8_SETUP)
         mem[a] = PRESENT[a - OFF_CHANNEL_1_SETUP] ? d : 8'h00;
      else if (a >= OFF_BIAS_DERIVE_POS_SELECT && a <= OFF_LEADOFF_POLARITY_SWAP)
         mem[a] = d & PRESENT;
      else
         mem[a] = d;
   endtask

   // Sends a single-byte command in a frame of its own.
   task automatic send_cmd(input logic [7:0] c);
      logic [7:0] rx;
      host_u.open_frame();
      host_u.xfer(c, rx);
      host_u.close_frame();
   endtask

   // Writes n_m1 + 1 registers from wbuf, starting at a.
   task automatic wr_burst(input logic [4:0] a, input logic [4:0] n_m1);
      logic [7:0] rx;
      host_u.open_frame();
      host_u.xfer({OP_WRITE, a}, rx);
      host_u.xfer({3'h0, n_m1}, rx);
      for (int i = 0; i <= n_m1; i++)
         host_u.xfer(wbuf[i], rx);
      host_u.close_frame();
   endtask

   // Reads n_m1 + 1 registers from a and compares each with the shadow copy.
   task automatic rd_check(input logic [4:0] a, input logic [4:0] n_m1);
      logic [7:0] rx;
      host_u.open_frame();
      host_u.xfer({OP_READ, a}, rx);
      host_u.xfer({3'h0, n_m1}, rx);
      for (int i = 0; i <= n_m1; i++)
         host_u.xfer(8'($random(seed)), rbuf[i]);
      host_u.close_frame();
      for (int i = 0; i <= n_m1; i++)
         `CHK("read data", exp_rd(5'(a + i)), rbuf[i])
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Cuts a hung run short.
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 90000)
      begin
         num_errors++;
         results();
      end
   end

   // Main sequence.
   initial
   begin
      seed      = 32'h972283c9;
      ce        = 1'b1;
      lo_pos    = 8'h00;
      lo_neg    = 8'h00;
      bias_stat = 1'b0;
      for (int i = 0; i < 32; i++)
         mem[i] = (i < 24) ? REG_RESET[i] : 8'h00;
      for (int g = 0; g < 8; g++)
         mem[5 + g] = PRESENT[g] ? mem[5 + g] : 8'h00;
      repeat (20) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      `CHK("cont mode", 1'b1, cont_mode)
      `CHK("rate setup", 8'h96, rate_out)
      `CHK("power down", 8'h00, chan_pd)
      // A read and a write while continuous output is on must both be ignored.
      send_cmd({OP_READ, OFF_RATE_CLOCK_SETUP});
      wbuf[0] = 8'h5a;
      wr_burst(OFF_RATE_CLOCK_SETUP, 5'h00);
      `CHK("rate setup", 8'h96, rate_out)
      send_cmd(CMD_STOP_CONT);
      `CHK("cont mode", 1'b0, cont_mode)
      // With the clock enable low the port is frozen and a write must not land.
      @(posedge clk_in);
      ce <= 1'b0;
      wbuf[0] = 8'h3c;
      wr_burst(OFF_RATE_CLOCK_SETUP, 5'h00);
      @(posedge clk_in);
      ce <= 1'b1;
      repeat (4) @(posedge clk_in);
      `CHK("rate frozen", 8'h96, rate_out)
      rd_check(OFF_IDENTITY_INFO, 5'h1f);
      // Random full-map writes, including read-only and unmapped places.
      for (int k = 0; k < 3; k++)
      begin
         for (int i = 0; i < 32; i++)
            wbuf[i] = 8'($random(seed));
         @(posedge clk_in);
         lo_pos    <= 8'($random(seed));
         lo_neg    <= 8'($random(seed));
         bias_stat <= 1'($random(seed));
         wr_burst(OFF_IDENTITY_INFO, 5'h1f);
         for (int i = 0; i < 32; i++)
            shadow_wr(5'(i), wbuf[i]);
         for (int g = 0; g < 8; g++)
            pd_exp[g] = mem[5 + g][7];
         `CHK("rate setup", mem[1], rate_out)
         `CHK("power down", pd_exp, chan_pd)
         rd_check(OFF_IDENTITY_INFO, 5'h1f);
      end
      // A short read running past the top of the map.
      rd_check(OFF_SPARE_CONTROL_B, 5'h03);
      send_cmd(CMD_CONT_OUT);
      `CHK("cont mode", 1'b1, cont_mode)
      results();
   end
endmodule
